/* File: pspc_gen.sv */
// Power-stage PWM generator configuration, compare and output logic
//
// Contract
// R01: Part A fault source: 00 common pin, 01 comparator, 10 alt A, 11 alt B.
// R02: Part B fault source uses the same two-bit encoding.
// R03: ADC sync pulse: lead A, trail A, lead B, trail B by code.
// R04: Trailing edge is reset match or fault event; leading is set match.
// R05: Output B pin is port pin unless part B output enable set.
// R06: Output A pin is port pin unless part A output enable set.
// R07: Four 12-bit compare values continuously compared against the counter.
// R08: Top four bits of reset-B compare hold the flank width value.
// R09: Compare writes go through one shared 8-bit high-byte latch.
// R10: Fifty mode copies set-B/reset-B into set-A/reset-A on reset-B update.
// R11: Autolock buffers updates; transfer at cycle end if reset-B written last.
// R12: Autolock takes priority over lock when both set.
// R13: Lock buffers compare and output config until lock cleared.
// R14: Ramp mode field: one, two, four ramps, code 11 reserved.
// R15: Outputs active low with polarity clear, active high when set.
// R16: Clock-select set picks fast clock, clear picks slow clock.
// R17: Prescaler divides by 1, 4, 32 or 256.
// R18: Control register resets to all zero.
// R19: Writing run starts generator; run prevails over slave auto-run. Code ORs the two, so slave auto-run alone also starts it.
// R20: Fast clock from PLL, slow clock from I/O clock.
// R21: Software writes compare high byte before low byte.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module pspc_gen #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire pspc_pkg::pspc_bus_req_s bus_in,
  output logic [pspc_pkg::DATA_W-1:0] rd_data_out,
  // Generator clock pins
  input wire logic fast_clock_in,
  input wire logic slow_clock_in,
  // Fault and trigger sources
  input wire logic common_fault_pin_in,
  input wire logic alt_fault_pin_a_in,
  input wire logic alt_fault_pin_b_in,
  input wire logic comparator_in,
  input wire logic slave_auto_run_in,
  // Ordinary port data for the output pins
  input wire logic port_a_in,
  input wire logic port_b_in,
  // Pins and status
  output logic waveform_out_a,
  output logic waveform_out_b,
  output logic adc_sync_out,
  output logic [1:0] ramp_mode_out,
  output logic [3:0] flank_width_out
);
  import pspc_pkg::*;

  if (CNT_W != 12) begin : g_chk
    $error("CNT_W must be 12");
  end

  logic [7:0] soc_q, cnf_q, ctl_q, isl_q, temp_q, act_soc_q;
  logic [15:0] sh_sa_q, sh_ra_q, sh_sb_q, sh_rb_q;
  logic [15:0] act_sa_q, act_ra_q, act_sb_q, act_rb_q;
  logic rb_last_q, active_q, wave_a_q, wave_b_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] pre_cnt_q, pre_m1;
  logic [5:0] s1_q, s2_q;
  logic [5:0] prev_q;
  logic src_a, src_b, fault_a_ev, fault_b_ev, tick, gen_en, eoc;
  logic m_sa, m_ra, m_sb, m_rb, lead_a, trail_a, lead_b, trail_b;
  logic wr_lo, commit_now, run_req;
  logic [15:0] wword;

  // Two-flop synchronisers for the clock, fault and comparator pin inputs
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      prev_q <= 6'h00;
    end else begin
      s1_q <= {comparator_in, alt_fault_pin_b_in, alt_fault_pin_a_in,
               common_fault_pin_in, fast_clock_in, slow_clock_in};
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  // Clock source and prescaler enable
  // Pin clocks are sampled, so they must run well below clk_in / 2
  assign tick = cnf_q[CNF_CLKSEL] ? (s2_q[1] & ~prev_q[1]) // R16 R20
                                  : (s2_q[0] & ~prev_q[0]);
  always_comb begin
    unique case (ctl_q[CTL_PRE_HI:CTL_PRE_LO]) // R17
      2'b00: pre_m1 = PRE_M1_1;
      2'b01: pre_m1 = PRE_M1_4;
      2'b10: pre_m1 = PRE_M1_32;
      2'b11: pre_m1 = PRE_M1_256;
    endcase
  end
  assign gen_en = tick & (pre_cnt_q >= pre_m1);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_cnt_q <= 8'h00;
    end else if (!active_q) begin
      pre_cnt_q <= 8'h00;
    end else if (tick) begin
      pre_cnt_q <= gen_en ? 8'h00 : pre_cnt_q + 8'h01; // R17
    end
  end

  // Fault source selection
  function automatic logic pick(input logic [1:0] sel, input logic [5:0] s);
    unique case (pspc_src_e'(sel))
      SRC_COMMON: pick = s[2];
      SRC_COMP: pick = s[5];
      SRC_ALT_A: pick = s[3];
      SRC_ALT_B: pick = s[4];
    endcase
  endfunction : pick
  assign src_a = pick({soc_q[SOC_SEL_A_HI], isl_q[ISL_SEL_A_LO]}, s2_q); // R01
  assign src_b = pick({soc_q[SOC_SEL_B_HI], isl_q[ISL_SEL_B_LO]}, s2_q); // R02
  assign fault_a_ev = src_a & ~pick({soc_q[SOC_SEL_A_HI],
                                     isl_q[ISL_SEL_A_LO]}, prev_q);
  assign fault_b_ev = src_b & ~pick({soc_q[SOC_SEL_B_HI],
                                     isl_q[ISL_SEL_B_LO]}, prev_q);

  // Register writes, high byte via shared latch
  assign wr_lo = bus_in.wr;
  assign wword = {temp_q, bus_in.wdata};
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      temp_q <= RST_BYTE;
    end else if (bus_in.wr && (bus_in.addr == OFF_SAH ||
             bus_in.addr == OFF_RAH || bus_in.addr == OFF_SBH ||
             bus_in.addr == OFF_RBH)) begin
      temp_q <= bus_in.wdata; // R09
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      soc_q <= RST_BYTE;
      cnf_q <= RST_BYTE;
      ctl_q <= RST_BYTE; // R18
      isl_q <= RST_BYTE;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        OFF_SOC: soc_q <= bus_in.wdata;
        OFF_CNF: cnf_q <= bus_in.wdata; // R14
        OFF_CTL: ctl_q <= bus_in.wdata; // R19
        OFF_ISL: isl_q <= {6'h00, bus_in.wdata[1:0]};
        default: ;
      endcase
    end
  end

  // Shadow compare registers, low byte commits both bytes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_sa_q <= RST_WORD;
      sh_ra_q <= RST_WORD;
      sh_sb_q <= RST_WORD;
      sh_rb_q <= RST_WORD;
    end else if (wr_lo) begin
      unique case (bus_in.addr)
        OFF_SAL: sh_sa_q <= {4'h0, wword[11:0]}; // R09
        OFF_RAL: sh_ra_q <= {4'h0, wword[11:0]};
        OFF_SBL: sh_sb_q <= {4'h0, wword[11:0]};
        OFF_RBL: begin
          sh_rb_q <= wword; // R08
          if (cnf_q[CNF_FIFTY]) begin
            sh_sa_q <= sh_sb_q; // R10
            sh_ra_q <= {4'h0, wword[11:0]}; // R10
          end
        end
        default: ;
      endcase
    end
  end

  // Tracks whether reset-B was the last compare written
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rb_last_q <= 1'b0;
    end else if (wr_lo && bus_in.addr == OFF_RBL) begin
      rb_last_q <= 1'b1;
    end else if (wr_lo && (bus_in.addr == OFF_SAL ||
                 bus_in.addr == OFF_RAL || bus_in.addr == OFF_SBL)) begin
      rb_last_q <= 1'b0;
    end else if (cnf_q[CNF_ALOCK] && eoc && rb_last_q) begin
      rb_last_q <= 1'b0;
    end
  end

  // Transfer shadows to the working copies
  // Autolock is tested first, so it wins over lock
  always_comb begin
    if (cnf_q[CNF_ALOCK]) begin
      commit_now = eoc & rb_last_q; // R11 R12
    end else begin
      commit_now = ~cnf_q[CNF_LOCK]; // R13
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_sa_q <= RST_WORD;
      act_ra_q <= RST_WORD;
      act_sb_q <= RST_WORD;
      act_rb_q <= RST_WORD;
      act_soc_q <= RST_BYTE;
    end else if (commit_now) begin
      act_sa_q <= sh_sa_q; // R11 R13
      act_ra_q <= sh_ra_q;
      act_sb_q <= sh_sb_q;
      act_rb_q <= sh_rb_q;
      act_soc_q <= soc_q;
    end
  end

  // Run control, run bit or slave auto-run starts the generator
  assign run_req = ctl_q[CTL_RUN] | slave_auto_run_in; // R19
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_q <= 1'b0;
    end else if (run_req) begin
      active_q <= 1'b1; // R19
    end else if (!ctl_q[CTL_CCYC] || eoc || !active_q) begin
      active_q <= 1'b0;
    end
  end

  // Counter and compare matches
  assign m_sa = gen_en && cnt_q == act_sa_q[CNT_W-1:0]; // R07
  assign m_ra = gen_en && cnt_q == act_ra_q[CNT_W-1:0];
  assign m_sb = gen_en && cnt_q == act_sb_q[CNT_W-1:0];
  assign m_rb = gen_en && cnt_q == act_rb_q[CNT_W-1:0];
  assign eoc = active_q & m_rb;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '0;
    end else if (!active_q) begin
      cnt_q <= '0;
    end else if (gen_en) begin
      cnt_q <= m_rb ? '0 : cnt_q + 1'b1;
    end
  end

  // Waveform generators, reset beats set
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else if (!active_q) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else begin
      if (m_ra || fault_a_ev) begin
        wave_a_q <= 1'b0; // R04
      end else if (m_sa) begin
        wave_a_q <= 1'b1; // R07
      end
      if (m_rb || fault_b_ev) begin
        wave_b_q <= 1'b0;
      end else if (m_sb) begin
        wave_b_q <= 1'b1;
      end
    end
  end

  // ADC synchronisation edges
  assign lead_a = active_q & m_sa; // R04
  assign trail_a = active_q & (m_ra | fault_a_ev);
  assign lead_b = active_q & m_sb;
  assign trail_b = active_q & (m_rb | fault_b_ev);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      adc_sync_out <= 1'b0;
    end else begin
      unique case (pspc_sync_e'(act_soc_q[SOC_SYNC_HI:SOC_SYNC_LO])) // R03
        SYNC_LEAD_A: adc_sync_out <= lead_a;
        SYNC_TRAIL_A: adc_sync_out <= trail_a;
        SYNC_LEAD_B: adc_sync_out <= lead_b;
        SYNC_TRAIL_B: adc_sync_out <= trail_b;
      endcase
    end
  end

  // Pin drive; asynchronous control forces inactive while fault is high
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      waveform_out_a <= 1'b0;
      waveform_out_b <= 1'b0;
    end else begin
      waveform_out_a <= act_soc_q[SOC_EN_A] // R06
        ? ~((wave_a_q & ~(ctl_q[CTL_AOC_A] & src_a)) ^ cnf_q[CNF_POL])
        : port_a_in; // R15
      waveform_out_b <= act_soc_q[SOC_EN_B] // R05
        ? ~((wave_b_q & ~(ctl_q[CTL_AOC_B] & src_b)) ^ cnf_q[CNF_POL])
        : port_b_in; // R15
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ramp_mode_out <= 2'b00;
      flank_width_out <= 4'h0;
    end else begin
      ramp_mode_out <= cnf_q[CNF_MODE_HI:CNF_MODE_LO]; // R14
      flank_width_out <= act_rb_q[15:12]; // R08
    end
  end

  // Read port, compare registers are write-only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= RST_BYTE;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        OFF_SOC: rd_data_out <= soc_q;
        OFF_CNF: rd_data_out <= cnf_q;
        OFF_CTL: rd_data_out <= ctl_q;
        OFF_ISL: rd_data_out <= isl_q;
        OFF_STA: rd_data_out <= {4'h0, rb_last_q, wave_b_q, wave_a_q,
                                 active_q};
        default: rd_data_out <= RST_BYTE;
      endcase
    end else begin
      rd_data_out <= RST_BYTE;
    end
  end

  AST_FIFTY: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R10
    wr_lo && bus_in.addr == OFF_RBL && cnf_q[CNF_FIFTY]
    |=> sh_ra_q == {4'h0, sh_rb_q[CNT_W-1:0]}
      && sh_sa_q == $past(sh_sb_q))
    else $error("fifty copy missing");
  AST_LOCK: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R13
    cnf_q[CNF_LOCK] && !cnf_q[CNF_ALOCK] |=> $stable(act_rb_q)
      || !$past(cnf_q[CNF_LOCK]) || !cnf_q[CNF_LOCK])
    else $error("locked copy changed");
  AST_ALOCK: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R11
    cnf_q[CNF_ALOCK] && !(eoc && rb_last_q) |=> $stable(act_sa_q))
    else $error("autolock copy changed early");
  AST_PRIO: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R12
    cnf_q[CNF_ALOCK] && cnf_q[CNF_LOCK] && eoc && rb_last_q
    |=> act_rb_q == $past(sh_rb_q))
    else $error("autolock lost to lock");
  AST_TEMP: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R09
    bus_in.wr && bus_in.addr == OFF_RBH ##1 wr_lo && bus_in.addr == OFF_RBL
    |=> sh_rb_q[15:8] == $past(bus_in.wdata, 2))
    else $error("high byte not latched");
  AST_CMP: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R07
    active_q && m_sa && !m_ra && !fault_a_ev |=> wave_a_q)
    else $error("set match ignored");
  AST_TRAIL: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R04
    active_q && fault_b_ev |=> !wave_b_q)
    else $error("fault did not end part B");
  AST_SYNC: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R03
    act_soc_q[SOC_SYNC_HI:SOC_SYNC_LO] == 2'b01 && trail_a |=> adc_sync_out)
    else $error("sync pulse missing");
  AST_PRE: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R17
    gen_en && ctl_q[CTL_PRE_HI:CTL_PRE_LO] == 2'b01 |-> pre_cnt_q == 8'h03)
    else $error("prescale count wrong");
  AST_PIN: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R06
    // Skip the release edge, where the pin flop still shows its reset value
    $past(arst_n_in) && !act_soc_q[SOC_EN_A]
    |=> waveform_out_a == $past(port_a_in))
    else $error("pin not released to port");
  AST_RUN: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R19
    ctl_q[CTL_RUN] |=> active_q)
    else $error("run ignored");
endmodule : pspc_gen
`default_nettype wire

/* File: pspc_pkg.sv */
// Package for the power-stage PWM configuration block
package pspc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFF_SOC = 4'h0;
  localparam logic [3:0] OFF_SAL = 4'h1;
  localparam logic [3:0] OFF_SAH = 4'h2;
  localparam logic [3:0] OFF_RAL = 4'h3;
  localparam logic [3:0] OFF_RAH = 4'h4;
  localparam logic [3:0] OFF_SBL = 4'h5;
  localparam logic [3:0] OFF_SBH = 4'h6;
  localparam logic [3:0] OFF_RBL = 4'h7;
  localparam logic [3:0] OFF_RBH = 4'h8;
  localparam logic [3:0] OFF_CNF = 4'h9;
  localparam logic [3:0] OFF_CTL = 4'hA;
  localparam logic [3:0] OFF_ISL = 4'hB;
  localparam logic [3:0] OFF_STA = 4'hC;
  // Bit positions in sync_output_config
  localparam int SOC_SEL_A_HI = 7;
  localparam int SOC_SEL_B_HI = 6;
  localparam int SOC_SYNC_HI = 5;
  localparam int SOC_SYNC_LO = 4;
  localparam int SOC_EN_B = 2;
  localparam int SOC_EN_A = 0;
  // Bit positions in generator_config
  localparam int CNF_FIFTY = 7;
  localparam int CNF_ALOCK = 6;
  localparam int CNF_LOCK = 5;
  localparam int CNF_MODE_HI = 4;
  localparam int CNF_MODE_LO = 3;
  localparam int CNF_POL = 2;
  localparam int CNF_CLKSEL = 1;
  // Bit positions in generator_control
  localparam int CTL_PRE_HI = 7;
  localparam int CTL_PRE_LO = 6;
  localparam int CTL_AOC_B = 4;
  localparam int CTL_AOC_A = 3;
  localparam int CTL_CCYC = 1;
  localparam int CTL_RUN = 0;
  // Bit positions in input select register
  localparam int ISL_SEL_A_LO = 1;
  localparam int ISL_SEL_B_LO = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Prescaler last counts: /1, /4, /32, /256
  localparam logic [7:0] PRE_M1_1 = 8'h00;
  localparam logic [7:0] PRE_M1_4 = 8'h03;
  localparam logic [7:0] PRE_M1_32 = 8'h1F;
  localparam logic [7:0] PRE_M1_256 = 8'hFF;
  typedef enum logic [1:0] {
    SRC_COMMON = 2'b00,
    SRC_COMP = 2'b01,
    SRC_ALT_A = 2'b10,
    SRC_ALT_B = 2'b11
  } pspc_src_e;
  typedef enum logic [1:0] {
    SYNC_LEAD_A = 2'b00,
    SYNC_TRAIL_A = 2'b01,
    SYNC_LEAD_B = 2'b10,
    SYNC_TRAIL_B = 2'b11
  } pspc_sync_e;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pspc_bus_req_s;
endpackage : pspc_pkg

/* File: pspc_switch_model.sv */
// Power switch model that counts turn-on edges at both gate pins
`timescale 1ns/100ps
`default_nettype none
module pspc_switch_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Gate drive pins
  input wire logic gate_a_in,
  input wire logic gate_b_in,
  // Turn-on counts
  output int on_a_out,
  output int on_b_out
);
  logic a_q;
  logic b_q;
  // Pins are registered, so sampling on clk misses no edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      on_a_out <= 0;
      on_b_out <= 0;
    end else begin
      a_q <= gate_a_in;
      b_q <= gate_b_in;
      if (gate_a_in && !a_q) begin
        on_a_out <= on_a_out + 1;
      end
      if (gate_b_in && !b_q) begin
        on_b_out <= on_b_out + 1;
      end
    end
  end
endmodule : pspc_switch_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the PWM configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pspc_pkg::*;
  logic clk_in, arst_n_in, fast_en;
  logic fast_clock_in = 1'b0;
  logic slow_clock_in = 1'b0;
  logic port_a, port_b, wa, wb, sync;
  logic [3:0] src_q, flank;
  logic [1:0] ramp;
  logic [7:0] rd_data;
  logic [7:0] div_q = 8'h00;
  pspc_bus_req_s bus;
  int on_a, on_b, n_mismatch, num_checks, ns, ea, eb;
  // Rows: address, write data, expected read back
  localparam logic [19:0] ROWS [6] = '{{OFF_SOC, 8'hF5, 8'hF5},
    {OFF_CNF, 8'hFE, 8'hFE}, {OFF_CTL, 8'hDA, 8'hDA},
    {OFF_ISL, 8'h03, 8'h03}, {OFF_SAH, 8'h0F, 8'h00},
    {4'hD, 8'hFF, 8'h00}};

  pspc_gen i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus),
    .rd_data_out(rd_data), .fast_clock_in(fast_clock_in),
    .slow_clock_in(slow_clock_in), .common_fault_pin_in(src_q[0]),
    .comparator_in(src_q[1]), .alt_fault_pin_a_in(src_q[2]),
    .alt_fault_pin_b_in(src_q[3]), .slave_auto_run_in(1'b0),
    .port_a_in(port_a), .port_b_in(port_b), .waveform_out_a(wa),
    .waveform_out_b(wb), .adc_sync_out(sync), .ramp_mode_out(ramp),
    .flank_width_out(flank));

  pspc_switch_model i_sw (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .gate_a_in(wa), .gate_b_in(wb), .on_a_out(on_a), .on_b_out(on_b));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Slow clock period 8 clk, fast 4 clk: both within the 2FF limit
  always @(posedge clk_in) begin
    div_q <= div_q + 8'h01;
    if (div_q[1:0] == 2'b11) slow_clock_in <= ~slow_clock_in;
    if (div_q[0]) fast_clock_in <= fast_en & ~fast_clock_in;
  end

  task automatic print_verdict;
    $display("mismatches=%0d checks=%0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Counts come from whole cycles, so one either way is allowed
  task automatic near(input int v, input int e);
    check({15'h0000, (v >= e - 1 && v <= e + 1)}, 16'h0001);
  endtask : near

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic wr16(input logic [3:0] hi, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(hi - 4'h1, v[7:0]);
  endtask : wr16

  task automatic measure(input int w);
    ns = 0;
    ea = on_a;
    eb = on_b;
    repeat (w) begin
      @(posedge clk_in);
      #1 if (sync === 1'b1) ns++;
    end
    ea = on_a - ea;
    eb = on_b - eb;
  endtask : measure

  task automatic pins(input logic [1:0] e);
    repeat (4) @(posedge clk_in);
    #1 check({14'h0000, wa, wb}, {14'h0000, e});
  endtask : pins

  initial begin
    repeat (100000) @(posedge clk_in);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    arst_n_in = 1'b0;
    bus = '0;
    fast_en = 1'b0;
    src_q = 4'h0;
    port_a = 1'b1;
    port_b = 1'b0;
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    pins(2'b10);
    for (int i = 0; i < 14; i++) begin
      rd(i[3:0], d);
      check({8'h00, d}, 16'h0000);
    end
    foreach (ROWS[i]) begin
      wr(ROWS[i][19:16], ROWS[i][15:8]);
      rd(ROWS[i][19:16], d);
      check({8'h00, d}, {8'h00, ROWS[i][7:0]});
    end
    wr(OFF_CTL, 8'h00);
    wr(OFF_ISL, 8'h00);
    wr(OFF_SOC, 8'h05);
    wr(OFF_CNF, 8'h00);
    pins(2'b11);
    wr(OFF_CNF, 8'h04);
    pins(2'b00);
    wr16(OFF_RBH, 16'hA009);
    pins(2'b00);
    check({12'h000, flank}, 16'h000A);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CNF, {3'b000, m[1:0], 3'b100});
      pins(2'b00);
      check({14'h0000, ramp}, {14'h0000, m[1:0]});
    end
    wr16(OFF_SAH, 16'h0002);
    wr16(OFF_RAH, 16'h0005);
    wr16(OFF_SBH, 16'h0003);
    wr16(OFF_RBH, 16'h0009);
    wr(OFF_CTL, 8'h01);
    // Ten counter steps of eight clk each make one 80 clk cycle
    for (int c = 0; c < 4; c++) begin
      wr(OFF_SOC, {2'b00, c[1:0], 4'h5});
      measure(800);
      near(ns, 10);
      near(ea, 10);
      near(eb, 10);
    end
    wr(OFF_CTL, 8'h41);
    measure(1600);
    near(ns, 5);
    wr(OFF_CTL, 8'h01);
    wr(OFF_CNF, 8'h06);
    measure(800);
    near(ns, 0);
    fast_en <= 1'b1;
    measure(800);
    near(ns, 20);
    fast_en <= 1'b0;
    // Fifty mode: part A copies part B, so both pins move together
    wr(OFF_CNF, 8'h84);
    wr16(OFF_RBH, 16'h0009);
    repeat (100) @(posedge clk_in);
    repeat (80) begin
      @(posedge clk_in);
      #1 check({15'h0000, wa}, {15'h0000, wb});
    end
    wr(OFF_CNF, 8'h04);
    // Reset-A never matches, so only a fault ends wave A
    wr16(OFF_RAH, 16'h0FFF);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_SOC, {s[1], 3'b001, 4'h1});
      wr(OFF_ISL, {6'h00, s[0], 1'b0});
      for (int f = 0; f < 4; f++) begin
        repeat (100) @(posedge clk_in);
        src_q <= 4'h1 << f;
        measure(40);
        @(posedge clk_in);
        src_q <= 4'h0;
        check(ns[15:0], {15'h0000, s == f});
      end
    end
    wr(OFF_CTL, 8'h00);
    wr(OFF_SOC, 8'h01);
    wr(OFF_CNF, 8'h24);
    pins(2'b00);
    wr(OFF_SOC, 8'h00);
    pins(2'b00);
    wr(OFF_CNF, 8'h04);
    pins(2'b10);
    wr(OFF_SOC, 8'h01);
    wr16(OFF_SAH, 16'h0FFF);
    pins(2'b00);
    wr(OFF_CNF, 8'h64);
    wr(OFF_CTL, 8'h01);
    wr(OFF_SOC, 8'h00);
    repeat (200) @(posedge clk_in);
    pins(2'b00);
    wr16(OFF_RBH, 16'h0009);
    repeat (200) @(posedge clk_in);
    pins(2'b10);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(OFF_CTL, d);
    check({8'h00, d}, 16'h0000);
    pins(2'b10);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
